// ### rtl/pfpf_pkg.sv
package pfpf_pkg;

   // ---------------------------------------------------------------
   // Pin drive levels.
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PFPF_LVL_LOW  = 2'h0,
      PFPF_LVL_MID  = 2'h1,
      PFPF_LVL_HIGH = 2'h2
   } pfpf_level_type;

   // ---------------------------------------------------------------
   // Register keys and field layout.
   // ---------------------------------------------------------------
   localparam logic [1:0] KEY_GAIN = 2'h1;
   localparam logic [1:0] KEY_QUIESCENT = 2'h2;
   localparam logic [1:0] KEY_TCPOL = 2'h3;
   localparam int CODE_WIDTH = 6;
   localparam logic [5:0] CODE_MAX = 6'h3F;
   localparam logic [5:0] TC_MAX = 6'h07;
   localparam logic [5:0] DIR_BIT = 6'h08;
   localparam logic [5:0] LOCK_BIT = 6'h10;

   // ---------------------------------------------------------------
   // Timing: figures in ns, counts derived at 250 MHz.
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_ACTIVE_HIGH_NS = 30000;
   localparam int T_ACTIVE_MID_NS = 15000;
   localparam int T_OFF_HIGH_NS = 30000;
   localparam int T_OFF_MID_NS = 5000;
   localparam int T_BLOW_NS = 30000;
   localparam int CYC_ACTIVE_HIGH = (T_ACTIVE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_ACTIVE_MID = (T_ACTIVE_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_OFF_HIGH = (T_OFF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_OFF_MID = (T_OFF_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_BLOW = (T_BLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pfpf_pkg

// ### rtl/pfpf_pulse_if.sv
`timescale 1ns/10ps
// Carries one pulse request from the sequencer to the pulse shaper.
interface pfpf_pulse_if;
   logic req;
   logic high;
   logic [15:0] active_cyc;
   logic [15:0] off_cyc;
   logic busy;
   logic done;
   modport seq (output req, output high, output active_cyc, output off_cyc,
      input busy, input done);
   modport shaper (input req, input high, input active_cyc, input off_cyc,
      output busy, output done);
endinterface : pfpf_pulse_if

// ### rtl/pfpf_pulse_gen.sv
`timescale 1ns/10ps
// Drives one pin pulse: the level for the active time, then low for the off time.
module pfpf_pulse_gen (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   pfpf_pulse_if.shaper pif,
   output pfpf_pkg::pfpf_level_type level_out
);
   logic [15:0] cnt_q, cnt_d;
   logic [1:0] ph_q, ph_d;
   logic hi_q, hi_d;
   logic [15:0] off_q, off_d;
   pfpf_pkg::pfpf_level_type lvl_q, lvl_d;
   logic done_q, done_d;
   logic [15:0] hi_run_q, hi_run_d;

   // ---------------------------------------------------------------
   // Phase 0 idle, 1 active level, 2 low recovery.
   // ---------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      ph_d = ph_q;
      hi_d = hi_q;
      off_d = off_q;
      lvl_d = lvl_q;
      done_d = 1'b0;
      case (ph_q)
         2'h0: begin
            if (pif.req) begin
               ph_d = 2'h1;
               hi_d = pif.high;
               off_d = pif.off_cyc;
               cnt_d = pif.active_cyc;
               lvl_d = pif.high ? pfpf_pkg::PFPF_LVL_HIGH : pfpf_pkg::PFPF_LVL_MID;
            end
         end
         2'h1: begin
            if (cnt_q <= 16'h0001) begin
               ph_d = 2'h2;
               cnt_d = off_q;
               lvl_d = pfpf_pkg::PFPF_LVL_LOW;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         default: begin
            if (cnt_q <= 16'h0001) begin
               ph_d = 2'h0;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= 16'h0000;
         ph_q <= 2'h0;
         hi_q <= 1'b0;
         off_q <= 16'h0000;
         lvl_q <= pfpf_pkg::PFPF_LVL_LOW;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ph_q <= ph_d;
         hi_q <= hi_d;
         off_q <= off_d;
         lvl_q <= lvl_d;
         done_q <= done_d;
      end
   end

   // Check helper: cycles the high level has stood so far.
   always_comb begin
      hi_run_d = 16'h0000;
      if (lvl_q == pfpf_pkg::PFPF_LVL_HIGH) begin
         hi_run_d = hi_run_q + 16'h0001;
      end
   end

   // Helper register only.
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hi_run_q <= 16'h0000;
      end else begin
         hi_run_q <= hi_run_d;
      end
   end

   assign pif.busy = (ph_q != 2'h0);
   assign pif.done = done_q;
   assign level_out = lvl_q;

   // Every high pulse holds the high level for at least 8 cycles after its request.
   a_high_width : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (ph_q == 2'h0 && pif.req && pif.high) |=> (lvl_q == pfpf_pkg::PFPF_LVL_HIGH) [*8])
      else $error("High pulse shorter than expected.");

   // A short high level would neither open a state nor blow a fuse reliably.
   a_high_full_length : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (lvl_q == pfpf_pkg::PFPF_LVL_HIGH && lvl_d != pfpf_pkg::PFPF_LVL_HIGH)
      |-> (hi_run_q >= 16'(pfpf_pkg::CYC_BLOW - 1)))
      else $error("High pulse ended before the blow time.");

   // The level on the pin must match the kind of pulse that was asked for.
   a_level_kind : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (ph_q == 2'h1) |-> (lvl_q == (hi_q ? pfpf_pkg::PFPF_LVL_HIGH : pfpf_pkg::PFPF_LVL_MID)))
      else $error("Pulse level differs from the requested kind.");

endmodule : pfpf_pulse_gen

// ### rtl/pfpf_programmer.sv
`timescale 1ns/10ps
// Behaviour
// - One high pulse enters key selection
// - Mid pulse count selects register key
// - High pulse after key enters addressing
// - High pulse in addressing blows addressed bit
// - Blow one bit per power cycle
// - Blow pulse high for at least 30 us
module pfpf_programmer #(
   parameter int POWER_OFF_CYC = 250000,
   parameter int POWER_ON_CYC = 250000
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic start_in,
   input wire logic [1:0] key_in,
   input wire logic [5:0] code_in,
   input wire logic blow_in,
   input wire logic locked_in,
   output logic [1:0] pin_level_out,
   output logic supply_on_out,
   output logic busy_out,
   output logic done_out,
   output logic error_out
);
   typedef enum logic [7:0] {
      PFPF_IDLE = 8'h01,
      PFPF_PWRUP = 8'h02,
      PFPF_ENTER = 8'h04,
      PFPF_KEY = 8'h08,
      PFPF_ADDR = 8'h10,
      PFPF_CODE = 8'h20,
      PFPF_BLOW = 8'h40,
      PFPF_PWROFF = 8'h80
   } pfpf_state_type;

   pfpf_pulse_if pif ();
   pfpf_pkg::pfpf_level_type lvl;

   pfpf_state_type st_q, st_d;
   logic [5:0] key_cnt_q, key_cnt_d;
   logic [5:0] code_cnt_q, code_cnt_d;
   logic [1:0] key_q, key_d;
   logic [5:0] tgt_q, tgt_d;
   logic blw_q, blw_d;
   logic [17:0] tmr_q, tmr_d;
   logic wait_q, wait_d;
   logic sup_q, sup_d;
   logic done_q, done_d;
   logic err_q, err_d;
   logic busy_q, busy_d;
   logic lk_s1_q, lk_s2_q;
   logic [1:0] lvl_q;

   // Returns true when a code holds more than one set bit.
   function automatic logic multi_bit(input logic [5:0] c);
      return (c & (c - 6'h01)) != 6'h00;
   endfunction : multi_bit

   // ---------------------------------------------------------------
   // Pulse shaper.
   // ---------------------------------------------------------------
   pfpf_pulse_gen u_pulse (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .pif(pif.shaper),
      .level_out(lvl)
   );

   // ---------------------------------------------------------------
   // Sequencer: power up, enter, key, addressing, optional blow.
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      key_cnt_d = key_cnt_q;
      code_cnt_d = code_cnt_q;
      key_d = key_q;
      tgt_d = tgt_q;
      blw_d = blw_q;
      tmr_d = tmr_q;
      wait_d = wait_q;
      sup_d = sup_q;
      done_d = 1'b0;
      err_d = err_q;
      pif.req = 1'b0;
      pif.high = 1'b0;
      pif.active_cyc = 16'(pfpf_pkg::CYC_ACTIVE_MID);
      pif.off_cyc = 16'(pfpf_pkg::CYC_OFF_MID);
      // A request stays pending until its pulse completes.
      if (wait_q && pif.done) begin
         wait_d = 1'b0;
      end
      case (st_q)
         PFPF_IDLE: begin
            if (start_in) begin
               // Lock refusal, bad key and multi-bit blow are caught up front.
               if (lk_s2_q || key_in == 2'h0 ||
                   (blow_in && (multi_bit(code_in) || code_in == 6'h00))) begin
                  err_d = 1'b1;
                  done_d = 1'b1;
               end else begin
                  err_d = 1'b0;
                  key_d = key_in;
                  tgt_d = code_in;
                  blw_d = blow_in;
                  sup_d = 1'b1;
                  tmr_d = 18'(POWER_ON_CYC);
                  st_d = PFPF_PWRUP;
               end
            end
         end
         PFPF_PWRUP: begin
            // Fresh power puts the device in initial with unblown bits zero.
            if (tmr_q == 18'h0_0000) begin
               st_d = PFPF_ENTER;
            end else begin
               tmr_d = tmr_q - 18'h0_0001;
            end
         end
         PFPF_ENTER: begin
            // High pulse opens key selection; no mid pulse is sent here.
            if (!wait_q && !pif.busy) begin
               pif.req = 1'b1;
               pif.high = 1'b1;
               pif.active_cyc = 16'(pfpf_pkg::CYC_ACTIVE_HIGH);
               pif.off_cyc = 16'(pfpf_pkg::CYC_OFF_HIGH);
               wait_d = 1'b1;
               key_cnt_d = 6'h00;
               st_d = PFPF_KEY;
            end
         end
         PFPF_KEY: begin
            // One mid pulse per key step selects the single register.
            if (!wait_q && !pif.busy) begin
               pif.req = 1'b1;
               wait_d = 1'b1;
               if (key_cnt_q == {4'h0, key_q}) begin
                  pif.high = 1'b1;
                  pif.active_cyc = 16'(pfpf_pkg::CYC_ACTIVE_HIGH);
                  pif.off_cyc = 16'(pfpf_pkg::CYC_OFF_HIGH);
                  code_cnt_d = 6'h00;
                  st_d = PFPF_ADDR;
               end else begin
                  key_cnt_d = key_cnt_q + 6'h01;
               end
            end
         end
         PFPF_ADDR: begin
            // Code counts up by one per mid pulse, never past the target.
            if (!wait_q && !pif.busy) begin
               if (code_cnt_q == tgt_q || code_cnt_q == pfpf_pkg::CODE_MAX) begin
                  st_d = blw_q ? PFPF_BLOW : PFPF_CODE;
               end else begin
                  pif.req = 1'b1;
                  wait_d = 1'b1;
                  code_cnt_d = code_cnt_q + 6'h01;
               end
            end
         end
         PFPF_CODE: begin
            // Try mode: supply stays up so the trial code can be measured.
            done_d = 1'b1;
            st_d = PFPF_IDLE;
         end
         PFPF_BLOW: begin
            // Blow pulse, then the supply is cycled before anything else.
            if (!wait_q && !pif.busy) begin
               pif.req = 1'b1;
               pif.high = 1'b1;
               pif.active_cyc = 16'(pfpf_pkg::CYC_BLOW);
               pif.off_cyc = 16'(pfpf_pkg::CYC_OFF_HIGH);
               wait_d = 1'b1;
               tmr_d = 18'(POWER_OFF_CYC);
               st_d = PFPF_PWROFF;
            end
         end
         PFPF_PWROFF: begin
            if (!wait_q && !pif.busy) begin
               sup_d = 1'b0;
               if (tmr_q == 18'h0_0000) begin
                  done_d = 1'b1;
                  st_d = PFPF_IDLE;
               end else begin
                  tmr_d = tmr_q - 18'h0_0001;
               end
            end
         end
         default: begin
            st_d = PFPF_IDLE;
         end
      endcase
      // A new request while the supply is up only powers down, then finishes.
      if (st_q == PFPF_IDLE && start_in && st_d == PFPF_PWRUP && sup_q) begin
         sup_d = 1'b0;
         tmr_d = 18'(POWER_OFF_CYC);
         st_d = PFPF_PWROFF;
         blw_d = 1'b0;
      end
      // Busy is registered from the next state, so the output stands on a flop.
      busy_d = (st_d != PFPF_IDLE);
   end

   // State registers only.
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= PFPF_IDLE;
         key_cnt_q <= 6'h00;
         code_cnt_q <= 6'h00;
         key_q <= 2'h0;
         tgt_q <= 6'h00;
         blw_q <= 1'b0;
         tmr_q <= 18'h0_0000;
         wait_q <= 1'b0;
         sup_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         busy_q <= 1'b0;
         lk_s1_q <= 1'b0;
         lk_s2_q <= 1'b0;
         lvl_q <= 2'h0;
      end else begin
         st_q <= st_d;
         key_cnt_q <= key_cnt_d;
         code_cnt_q <= code_cnt_d;
         key_q <= key_d;
         tgt_q <= tgt_d;
         blw_q <= blw_d;
         tmr_q <= tmr_d;
         wait_q <= wait_d;
         sup_q <= sup_d;
         done_q <= done_d;
         err_q <= err_d;
         busy_q <= busy_d;
         lk_s1_q <= locked_in;
         lk_s2_q <= lk_s1_q;
         lvl_q <= lvl;
      end
   end

   assign pin_level_out = lvl_q;
   assign supply_on_out = sup_q;
   assign busy_out = busy_q;
   assign done_out = done_q;
   assign error_out = err_q;

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   sequence s_blow_issued;
      (st_q == PFPF_BLOW) && pif.req;
   endsequence

   a_no_start_locked : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_IDLE && start_in && lk_s2_q) |=> (st_q == PFPF_IDLE && err_q))
      else $error("Programming started on a locked part.");
   a_code_saturates : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (code_cnt_q <= pfpf_pkg::CODE_MAX) && !(st_q == PFPF_ADDR && code_cnt_q > tgt_q))
      else $error("Code counter ran past its target.");
   a_code_only_up : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_ADDR && $past(st_q) == PFPF_ADDR) |-> code_cnt_q >= $past(code_cnt_q))
      else $error("Code decremented.");
   a_blow_single : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_BLOW) |-> !multi_bit(tgt_q))
      else $error("Blow of several bits at once.");
   a_blow_then_off : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      s_blow_issued |=> (st_q == PFPF_PWROFF) [*8])
      else $error("Supply not cycled after blow.");
   a_key_count : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_KEY && st_d == PFPF_ADDR) |-> key_cnt_q == {4'h0, key_q})
      else $error("Wrong key pulse count.");
   a_enter_high : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_ENTER && pif.req) |-> pif.high)
      else $error("Mid pulse sent in initial state.");
   a_try_keeps_power : assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (st_q == PFPF_CODE) |=> sup_q)
      else $error("Trial code lost by power drop.");

endmodule : pfpf_programmer

// ### verification/pfpf_device_model.sv
`timescale 1ns/10ps
// Behavioural sensor: decodes pin pulses into keys, codes and fuse blows.
module pfpf_device_model (
   input wire logic ref_clk_in,
   input wire logic [1:0] pin_level_in,
   input wire logic supply_on_in,
   output logic [5:0] gain_code_out,
   output logic [5:0] quiescent_level_code_out,
   output logic [5:0] tempco_polarity_lock_out
);
   // --------
   // State.
   // --------
   typedef enum logic [1:0] {ST_INIT, ST_SEL, ST_ADDR, ST_DONE} pfpf_dev_state_type;
   pfpf_dev_state_type state_q = ST_INIT;
   logic [1:0] key_q = 2'h0;
   logic [5:0] trial_q = 6'h00;
   logic [5:0] fuse_q [1:3] = '{6'h00, 6'h00, 6'h00};
   logic [1:0] prev_q = 2'h0;
   int high_len_q = 0;
   logic mid_evt;
   logic high_evt;
   logic lock_w;

   // A pulse counts on its return to low, so its kind is known by then.
   assign mid_evt = (prev_q == pfpf_pkg::PFPF_LVL_MID) && (pin_level_in == 2'h0);
   assign high_evt = (prev_q == pfpf_pkg::PFPF_LVL_HIGH) && (pin_level_in == 2'h0);
   assign lock_w = fuse_q[3][4];

   // Sequencing; fuses survive power loss, the rest does not.
   always @(posedge ref_clk_in) begin
      prev_q <= pin_level_in;
      high_len_q <= (pin_level_in == pfpf_pkg::PFPF_LVL_HIGH) ? high_len_q + 1 : 0;
      if (supply_on_in !== 1'b1) begin
         state_q <= ST_INIT;
         key_q <= 2'h0;
         trial_q <= 6'h00;
      end else if (mid_evt && !lock_w) begin
         case (state_q)
            ST_SEL: key_q <= (key_q == 2'h3) ? key_q : key_q + 2'h1;
            ST_ADDR: trial_q <= (trial_q == 6'h3f) ? trial_q : trial_q + 6'h01;
            default: ;
         endcase
      end else if (high_evt && !lock_w) begin
         case (state_q)
            ST_INIT: state_q <= ST_SEL;
            ST_SEL: if (key_q != 2'h0) state_q <= ST_ADDR;
            ST_ADDR: if (high_len_q >= pfpf_pkg::CYC_BLOW) begin
               fuse_q[key_q] <= fuse_q[key_q] | trial_q;
               state_q <= ST_DONE;
            end
            default: ;
         endcase
      end
   end

   // Trial value only on the selected register; fuses always show.
   always_comb begin
      gain_code_out = fuse_q[1];
      quiescent_level_code_out = fuse_q[2];
      tempco_polarity_lock_out = fuse_q[3];
      if (state_q == ST_ADDR || state_q == ST_DONE) begin
         case (key_q)
            2'h1: gain_code_out = fuse_q[1] | trial_q;
            2'h2: quiescent_level_code_out = fuse_q[2] | trial_q;
            2'h3: tempco_polarity_lock_out = fuse_q[3] | trial_q;
            default: ;
         endcase
      end
   end
endmodule : pfpf_device_model

// ### verification/pulse_fuse_programming_fsm_tb.sv
`timescale 1ns/10ps
// Bench: the sequencer drives the device model; results are read from the model.
module pulse_fuse_programming_fsm_tb;
   localparam int OP_LIMIT = 60000;
   localparam int RUN_LIMIT = 102000;
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic start_in = 1'b0;
   logic [1:0] key_in = 2'h0;
   logic [5:0] code_in = 6'h00;
   logic blow_in = 1'b0;
   logic locked_in = 1'b0;
   logic [1:0] pin_level;
   logic supply_on;
   logic busy;
   logic done;
   logic error;
   logic [5:0] gain;
   logic [5:0] quiescent;
   logic [5:0] tcpol;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;

   // Clock at 250 MHz.
   always #2 ref_clk_in = ~ref_clk_in;

   // Power phases shortened so the run stays brief.
   pfpf_programmer #(.POWER_OFF_CYC(20), .POWER_ON_CYC(20)) i_dut (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .start_in(start_in),
      .key_in(key_in),
      .code_in(code_in),
      .blow_in(blow_in),
      .locked_in(locked_in),
      .pin_level_out(pin_level),
      .supply_on_out(supply_on),
      .busy_out(busy),
      .done_out(done),
      .error_out(error)
   );

   pfpf_device_model i_dev (
      .ref_clk_in(ref_clk_in),
      .pin_level_in(pin_level),
      .supply_on_in(supply_on),
      .gain_code_out(gain),
      .quiescent_level_code_out(quiescent),
      .tempco_polarity_lock_out(tcpol)
   );

   // --------
   // Shared tasks.
   // --------
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // One request; start pulses for one cycle, key, code and blow stay put until the done pulse is seen.
   task automatic run_op(input logic [1:0] k, input logic [5:0] c, input logic b);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      start_in <= 1'b1;
      key_in <= k;
      code_in <= c;
      blow_in <= b;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (done !== 1'b1 && n < OP_LIMIT);
      // A request that never finishes is a failure, not a silent skip.
      if (done !== 1'b1) begin
         n_fail++;
      end
   endtask : run_op

   // --------
   // Scenarios.
   // --------
   task automatic t_reset;
      check({6'h00, pin_level, supply_on, busy, done, error, gain}, 20'h0_0000);
      check({8'h00, quiescent, tcpol}, 20'h0_0000);
   endtask : t_reset

   // Bad key, two-bit blow and a locked part are all refused untouched.
   task automatic t_refuse;
      logic [1:0] k [3] = '{2'h0, 2'h1, 2'h1};
      logic [5:0] c [3] = '{6'h01, 6'h03, 6'h01};
      logic b [3] = '{1'b0, 1'b1, 1'b0};
      logic l [3] = '{1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk_in);
         locked_in <= l[i];
         repeat (3) @(posedge ref_clk_in);
         run_op(k[i], c[i], b[i]);
         check({done, error, supply_on, 5'h00, gain, tcpol}, 20'hc_0000);
      end
      @(posedge ref_clk_in);
      locked_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
   endtask : t_refuse

   // One mid pulse on the quiescent register; value held afterwards.
   task automatic t_try;
      run_op(2'h2, 6'h01, 1'b0);
      check({error, supply_on, gain, quiescent, tcpol}, 20'h4_0040);
      repeat (200) @(negedge ref_clk_in);
      check({error, supply_on, gain, quiescent, tcpol}, 20'h4_0040);
      check({17'h0_0000, busy, pin_level}, 20'h0_0000);
   endtask : t_try

   // Power cycle wipes the trial, then a blown bit stays through power-off.
   task automatic t_blow;
      run_op(2'h1, 6'h01, 1'b1);
      check({error, supply_on, gain, quiescent, tcpol}, 20'h0_0000);
      run_op(2'h1, 6'h01, 1'b1);
      check({error, supply_on, gain, quiescent, tcpol}, 20'h0_1000);
   endtask : t_blow

   // Cut a hang short and count it as a mismatch.
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == RUN_LIMIT) begin
         n_fail++;
         stop_test();
      end
   end

   // Main sequence.
   initial begin
      repeat (3) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      t_reset();
      t_refuse();
      t_try();
      t_blow();
      stop_test();
   end
endmodule : pulse_fuse_programming_fsm_tb
